// file: src/tcep_pkg.sv
// Purpose: Constants for the timer channel enable and polarity block
// Assumes: 8-bit byte address, 32-bit register words
// Notes:   Offsets are byte addresses on the plain register port
package tcep_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_LANES       = 5;

    // Register offsets
    localparam logic [7:0]  OFS_CHAN_ENABLE = 8'h20;
    localparam logic [7:0]  OFS_CHAN_MODE   = 8'h40;
    localparam logic [7:0]  OFS_PROTECT     = 8'h44;
    localparam logic [7:0]  OFS_CAPT_FLAGS  = 8'h48;
    localparam logic [7:0]  OFS_PIN_STATE   = 8'h4c;

    // Channel enable register fields
    localparam int          CH0_EN_BIT      = 0;
    localparam int          CH0_POL_BIT     = 1;
    localparam int          MCH0_EN_BIT     = 2;
    localparam int          MCH0_POL_BIT    = 3;
    localparam int          CH1_EN_BIT      = 4;
    localparam int          CH1_POL_BIT     = 5;
    localparam int          MCH1_EN_BIT     = 6;
    localparam int          MCH1_POL_BIT    = 7;
    localparam int          CH2_EN_BIT      = 8;
    localparam int          CH2_POL_BIT     = 9;
    localparam logic [9:0]  ENABLE_WR_MASK  = 10'h3ff;
    localparam logic [9:0]  POLARITY_MASK   = 10'h2aa;

    // Channel mode register fields
    localparam int          CH0_MODE_LSB    = 0;
    localparam int          CH1_MODE_LSB    = 2;
    localparam int          CH2_MODE_LSB    = 4;
    localparam int          MSEL0_LSB       = 6;
    localparam int          MSEL1_LSB       = 8;
    localparam int          CH0_PSC_LSB     = 10;
    localparam int          CH1_PSC_LSB     = 12;
    localparam int          CH2_PSC_LSB     = 14;
    localparam logic [1:0]  MODE_OUTPUT     = 2'h0;
    localparam logic [1:0]  MSEL_POLARITY   = 2'h3;

    // Protection level field
    localparam int          WRITE_PROTECT_LEVEL_LSB        = 0;
    localparam logic [1:0]  WRITE_PROTECT_LEVEL_LOCK_HI    = 2'h3;
    localparam logic [1:0]  WRITE_PROTECT_LEVEL_LOCK_LO    = 2'h2;

    // Edge selections {complementary polarity, polarity}
    localparam logic [1:0]  EDGE_RISE       = 2'h0;
    localparam logic [1:0]  EDGE_FALL       = 2'h1;
    localparam logic [1:0]  EDGE_RSVD       = 2'h2;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;

    // Reset values
    localparam logic [9:0]  RST_CHAN_ENABLE = 10'h000;
    localparam logic [15:0] RST_CHAN_MODE   = 16'h0000;
    localparam logic [1:0]  RST_PROTECT     = 2'h0;
    localparam logic [4:0]  RST_CAPT_FLAGS  = 5'h00;
endpackage

// file: src/tcep_capt.sv
// Purpose: Edge selection and capture prescaler for one channel lane
// Assumes: Pin input synchronous to mclk
// Notes:   Event is a one-cycle registered pulse
`timescale 1ns/100ps
module tcep_capt
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       enable,
    input  wire logic       input_mode,
    input  wire logic [1:0] edge_sel,
    input  wire logic [1:0] psc,
    // Pin and event
    input  wire logic       pin,
    output logic            event_out
);
    logic       prev;
    logic [2:0] cnt;
    logic       next_prev;
    logic [2:0] next_cnt;
    logic       next_event;
    logic       edge_hit;
    logic [2:0] limit;

    always_comb
    begin
        unique case (edge_sel)
            tcep_pkg::EDGE_RISE: edge_hit = pin & ~prev;
            tcep_pkg::EDGE_FALL: edge_hit = ~pin & prev;
            tcep_pkg::EDGE_BOTH: edge_hit = pin ^ prev;
            tcep_pkg::EDGE_RSVD: edge_hit = 1'b0; // Reserved: no capture
        endcase
        unique case (psc)
            2'h0: limit = 3'h0;
            2'h1: limit = 3'h1;
            2'h2: limit = 3'h3;
            2'h3: limit = 3'h7;
        endcase
        next_prev  = pin;
        next_cnt   = cnt;
        next_event = 1'b0;
        if (!enable)
        begin
            next_cnt = 3'h0;
        end
        else if (input_mode && edge_hit)
        begin
            if (cnt >= limit)
            begin
                next_cnt   = 3'h0;
                next_event = 1'b1;
            end
            else
            begin
                next_cnt = cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev      <= 1'b0;
            cnt       <= 3'h0;
            event_out <= 1'b0;
        end
        else
        begin
            prev      <= next_prev;
            cnt       <= next_cnt;
            event_out <= next_event;
        end
    end
endmodule

// file: src/tcep_outp.sv
// Purpose: Output gating and polarity for one channel lane
// Assumes: Reference is active high from the compare logic
// Notes:   Disabled or input lanes drive a low pin
`timescale 1ns/100ps
module tcep_outp
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Control
    input  wire logic enable,
    input  wire logic input_mode,
    input  wire logic polarity,
    // Reference and pin
    input  wire logic ref_active,
    output logic      pin_out
);
    logic next_pin;

    always_comb
    begin
        next_pin = 1'b0;
        if (enable && !input_mode)
        begin
            next_pin = ref_active ^ polarity;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out <= 1'b0;
        end
        else
        begin
            pin_out <= next_pin;
        end
    end
endmodule

// file: src/tcep_top.sv
// Purpose: Timer channel enable and polarity controls, channels 0 to 2
// Assumes: Inputs synchronous to mclk, plain register port
// Notes:   Lane order 0 ch0, 1 comp ch0, 2 ch1, 3 comp ch1, 4 ch2
//
// Behaviour
// - With complementary channel 0 in output mode and mode select 11, bit 3 picks its output polarity, 1 meaning active low.
// - Bit 2 enables complementary channel 0, driving its output in output mode or allowing its captures in input mode.
// - In output mode bit 1 picks the channel 0 output polarity, 1 meaning active low.
// - In input mode the pair of complementary and channel polarity bits selects rising, falling, reserved or both edges.
// - Bit 0 enables channel 0, driving its output in output mode or allowing its captures in input mode.
// - Writes to the polarity bits are ignored while the protection level is 11 or 10.
// - Channel 1 follows channel 0 with enable, polarity and complementary bits at 4, 5, 6 and 7.
// - Channel 2 follows channel 0 with enable at bit 8 and polarity at bit 9.
// - Clearing the channel 2 enable resets its capture prescaler.
`timescale 1ns/100ps
module tcep_top
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Compare references, active high
    input  wire logic [2:0]  oc_ref,
    // Capture pins
    input  wire logic [2:0]  chan_in,
    input  wire logic [1:0]  comp_chan_in,
    // Channel outputs
    output logic             chan0_out,
    output logic             comp_chan0_out,
    output logic             chan1_out,
    output logic             comp_chan1_out,
    output logic             chan2_out,
    // Capture event pulses, one per lane
    output logic      [4:0]  capture_event
);
    logic [9:0]  chan_enable_reg;
    logic [15:0] chan_mode;
    logic [1:0]  write_protect_level;
    logic [4:0]  capt_flags;
    logic [9:0]  next_chan_enable_reg;
    logic [15:0] next_chan_mode;
    logic [1:0]  next_write_protect_level;
    logic [4:0]  next_capt_flags;
    logic [31:0] next_reg_rdata;
    logic        pol_locked;
    logic [9:0]  wr_keep;

    // Field views
    logic        chan0_enable;
    logic        chan0_polarity;
    logic        comp_chan0_enable;
    logic        comp_chan0_polarity;
    logic        chan1_enable;
    logic        chan1_polarity;
    logic        comp_chan1_enable;
    logic        comp_chan1_polarity;
    logic        chan2_enable;
    logic        chan2_polarity;
    logic [1:0]  comp_chan0_mode_select;
    logic [1:0]  comp_chan1_mode_select;
    logic        ch0_in_mode;
    logic        ch1_in_mode;
    logic        ch2_in_mode;

    // Lane vectors
    logic [4:0]  lane_en;
    logic [4:0]  lane_in_mode;
    logic [4:0]  lane_out_pol;
    logic [4:0]  lane_ref;
    logic [4:0]  lane_pin;
    logic [4:0]  lane_out;
    logic [9:0]  lane_edge;
    logic [9:0]  lane_psc;

    assign chan0_enable        = chan_enable_reg[tcep_pkg::CH0_EN_BIT];
    assign chan0_polarity      = chan_enable_reg[tcep_pkg::CH0_POL_BIT];
    assign comp_chan0_enable   = chan_enable_reg[tcep_pkg::MCH0_EN_BIT];
    assign comp_chan0_polarity = chan_enable_reg[tcep_pkg::MCH0_POL_BIT];
    assign chan1_enable        = chan_enable_reg[tcep_pkg::CH1_EN_BIT];
    assign chan1_polarity      = chan_enable_reg[tcep_pkg::CH1_POL_BIT];
    assign comp_chan1_enable   = chan_enable_reg[tcep_pkg::MCH1_EN_BIT];
    assign comp_chan1_polarity = chan_enable_reg[tcep_pkg::MCH1_POL_BIT];
    assign chan2_enable        = chan_enable_reg[tcep_pkg::CH2_EN_BIT];
    assign chan2_polarity      = chan_enable_reg[tcep_pkg::CH2_POL_BIT];

    assign comp_chan0_mode_select =
        chan_mode[tcep_pkg::MSEL0_LSB +: 2];
    assign comp_chan1_mode_select =
        chan_mode[tcep_pkg::MSEL1_LSB +: 2];
    assign ch0_in_mode =
        chan_mode[tcep_pkg::CH0_MODE_LSB +: 2] != tcep_pkg::MODE_OUTPUT;
    assign ch1_in_mode =
        chan_mode[tcep_pkg::CH1_MODE_LSB +: 2] != tcep_pkg::MODE_OUTPUT;
    assign ch2_in_mode =
        chan_mode[tcep_pkg::CH2_MODE_LSB +: 2] != tcep_pkg::MODE_OUTPUT;

    // Enables per lane
    assign lane_en = {chan2_enable,
                      comp_chan1_enable,
                      chan1_enable,
                      comp_chan0_enable,
                      chan0_enable};

    // Complementary lanes share the mode of their main channel
    assign lane_in_mode = {ch2_in_mode, ch1_in_mode, ch1_in_mode,
                           ch0_in_mode, ch0_in_mode};

    // Output polarity; complementary polarity only with mode select 11
    assign lane_out_pol[0] = chan0_polarity;
    assign lane_out_pol[1] = comp_chan0_polarity &
        (comp_chan0_mode_select == tcep_pkg::MSEL_POLARITY);
    assign lane_out_pol[2] = chan1_polarity;
    assign lane_out_pol[3] = comp_chan1_polarity &
        (comp_chan1_mode_select == tcep_pkg::MSEL_POLARITY);
    assign lane_out_pol[4] = chan2_polarity;

    // Complementary references; dead time is handled elsewhere
    assign lane_ref = {oc_ref[2], ~oc_ref[1], oc_ref[1],
                       ~oc_ref[0], oc_ref[0]};
    assign lane_pin = {chan_in[2], comp_chan_in[1], chan_in[1],
                       comp_chan_in[0], chan_in[0]};

    // Input edge pair {complementary polarity, polarity}
    assign lane_edge[1:0] = {comp_chan0_polarity, chan0_polarity};
    assign lane_edge[3:2] = {comp_chan0_polarity, chan0_polarity};
    assign lane_edge[5:4] = {comp_chan1_polarity, chan1_polarity};
    assign lane_edge[7:6] = {comp_chan1_polarity, chan1_polarity};
    // No complementary polarity bit for channel 2 here
    assign lane_edge[9:8] = {1'b0, chan2_polarity};

    assign lane_psc = {chan_mode[tcep_pkg::CH2_PSC_LSB +: 2],
                       chan_mode[tcep_pkg::CH1_PSC_LSB +: 2],
                       chan_mode[tcep_pkg::CH1_PSC_LSB +: 2],
                       chan_mode[tcep_pkg::CH0_PSC_LSB +: 2],
                       chan_mode[tcep_pkg::CH0_PSC_LSB +: 2]};

    genvar gi;
    generate
        for (gi = 0; gi < tcep_pkg::NUM_LANES; gi = gi + 1)
        begin : g_lane
            tcep_outp u_outp
            (
                .mclk       (mclk),
                .reset_n    (reset_n),
                .enable     (lane_en[gi]),
                .input_mode (lane_in_mode[gi]),
                .polarity   (lane_out_pol[gi]),
                .ref_active (lane_ref[gi]),
                .pin_out    (lane_out[gi])
            );
            tcep_capt u_capt
            (
                .mclk       (mclk),
                .reset_n    (reset_n),
                .enable     (lane_en[gi]),
                .input_mode (lane_in_mode[gi]),
                .edge_sel   (lane_edge[2*gi +: 2]),
                .psc        (lane_psc[2*gi +: 2]),
                .pin        (lane_pin[gi]),
                .event_out  (capture_event[gi])
            );
        end
    endgenerate

    assign chan0_out      = lane_out[0];
    assign comp_chan0_out = lane_out[1];
    assign chan1_out      = lane_out[2];
    assign comp_chan1_out = lane_out[3];
    assign chan2_out      = lane_out[4];

    // Protection freezes polarity so a runaway write cannot flip drive
    assign pol_locked =
        (write_protect_level == tcep_pkg::WRITE_PROTECT_LEVEL_LOCK_HI) ||
        (write_protect_level == tcep_pkg::WRITE_PROTECT_LEVEL_LOCK_LO);
    assign wr_keep = pol_locked ? tcep_pkg::POLARITY_MASK : 10'h000;

    always_comb
    begin
        next_chan_enable_reg     = chan_enable_reg;
        next_chan_mode           = chan_mode;
        next_write_protect_level = write_protect_level;
        next_reg_rdata           = 32'h0000_0000;
        // Set wins over a clear in the same cycle
        next_capt_flags          = capt_flags;
        if (reg_wr)
        begin
            unique case (reg_addr)
                tcep_pkg::OFS_CHAN_ENABLE:
                begin
                    next_chan_enable_reg =
                        (chan_enable_reg & wr_keep) |
                        (reg_wdata[9:0] & tcep_pkg::ENABLE_WR_MASK &
                         ~wr_keep);
                end
                tcep_pkg::OFS_CHAN_MODE:
                begin
                    next_chan_mode = reg_wdata[15:0];
                end
                tcep_pkg::OFS_PROTECT:
                begin
                    next_write_protect_level =
                        reg_wdata[tcep_pkg::WRITE_PROTECT_LEVEL_LSB +: 2];
                end
                tcep_pkg::OFS_CAPT_FLAGS:
                begin
                    next_capt_flags = capt_flags & ~reg_wdata[4:0];
                end
                default:
                begin
                    next_capt_flags = capt_flags;
                end
            endcase
        end
        next_capt_flags = next_capt_flags | capture_event;
        if (reg_rd)
        begin
            unique case (reg_addr)
                tcep_pkg::OFS_CHAN_ENABLE:
                    next_reg_rdata = {22'h000000, chan_enable_reg};
                tcep_pkg::OFS_CHAN_MODE:
                    next_reg_rdata = {16'h0000, chan_mode};
                tcep_pkg::OFS_PROTECT:
                    next_reg_rdata = {30'h00000000, write_protect_level};
                tcep_pkg::OFS_CAPT_FLAGS:
                    next_reg_rdata = {27'h0000000, capt_flags};
                tcep_pkg::OFS_PIN_STATE:
                    next_reg_rdata = {22'h000000, lane_pin, lane_out};
                default:
                    next_reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chan_enable_reg     <= tcep_pkg::RST_CHAN_ENABLE;
            chan_mode           <= tcep_pkg::RST_CHAN_MODE;
            write_protect_level <= tcep_pkg::RST_PROTECT;
            capt_flags          <= tcep_pkg::RST_CAPT_FLAGS;
            reg_rdata           <= 32'h0000_0000;
        end
        else
        begin
            chan_enable_reg     <= next_chan_enable_reg;
            chan_mode           <= next_chan_mode;
            write_protect_level <= next_write_protect_level;
            capt_flags          <= next_capt_flags;
            reg_rdata           <= next_reg_rdata;
        end
    end
endmodule

// file: dv/tcep_props.sv
// Purpose: Port checks for the channel enable and polarity block
// Assumes: Shadow registers follow bus writes exactly
// Notes:   Shadow keeps the lock so that readback can be compared
`timescale 1ns/100ps
module tcep_props
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Pins
    input wire logic [2:0]  oc_ref,
    input wire logic [2:0]  chan_in,
    input wire logic        chan0_out,
    input wire logic        comp_chan0_out,
    input wire logic        chan1_out,
    input wire logic        comp_chan1_out,
    input wire logic        chan2_out,
    input wire logic [4:0]  capture_event
);
    logic [9:0]  en_r;
    logic [15:0] md_r;
    logic [1:0]  pr_r;
    logic [9:0]  lock;
    logic [4:0]  exp_o;
    logic        in0;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Lock covers polarity bits only
    assign lock = pr_r[1] ? tcep_pkg::POLARITY_MASK : 10'h000;
    assign in0 = (md_r[1:0] != 2'h0) && (md_r[11:10] == 2'h0);
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_r <= 10'h000;
            md_r <= 16'h0000;
            pr_r <= 2'h0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == tcep_pkg::OFS_CHAN_ENABLE)
                en_r <= (reg_wdata[9:0] & ~lock) | (en_r & lock);
            if (reg_addr == tcep_pkg::OFS_CHAN_MODE)
                md_r <= reg_wdata[15:0];
            if (reg_addr == tcep_pkg::OFS_PROTECT)
                pr_r <= reg_wdata[1:0];
        end
    end

    // Comp lanes see the inverted reference
    always_comb
    begin
        exp_o[0] = en_r[0] & (md_r[1:0] == 2'h0) & (oc_ref[0] ^ en_r[1]);
        exp_o[1] = en_r[2] & (md_r[1:0] == 2'h0)
                   & (~oc_ref[0] ^ ((md_r[7:6] == 2'h3) & en_r[3]));
        exp_o[2] = en_r[4] & (md_r[3:2] == 2'h0) & (oc_ref[1] ^ en_r[5]);
        exp_o[3] = en_r[6] & (md_r[3:2] == 2'h0)
                   & (~oc_ref[1] ^ ((md_r[9:8] == 2'h3) & en_r[7]));
        exp_o[4] = en_r[8] & (md_r[5:4] == 2'h0) & (oc_ref[2] ^ en_r[9]);
    end

    property p_ch0_out;
        chan0_out == $past(exp_o[0]);
    endproperty
    a_ch0_out: assert property (p_ch0_out) else $error("ch0 out");
    property p_cmp0_out;
        comp_chan0_out == $past(exp_o[1]);
    endproperty
    a_cmp0_out: assert property (p_cmp0_out) else $error("cmp0 out");
    property p_ch1_out;
        chan1_out == $past(exp_o[2]);
    endproperty
    a_ch1_out: assert property (p_ch1_out) else $error("ch1 out");
    property p_cmp1_out;
        comp_chan1_out == $past(exp_o[3]);
    endproperty
    a_cmp1_out: assert property (p_cmp1_out) else $error("cmp1 out");
    property p_ch2_out;
        chan2_out == $past(exp_o[4]);
    endproperty
    a_ch2_out: assert property (p_ch2_out) else $error("ch2 out");
    property p_en_read;
        reg_rd && reg_addr == tcep_pkg::OFS_CHAN_ENABLE
            |=> reg_rdata == {22'h0, $past(en_r)};
    endproperty
    a_en_read: assert property (p_en_read) else $error("readback");
    property p_cap_rise;
        $rose(chan_in[0]) && en_r[0] && in0 && {en_r[3], en_r[1]} == 2'h0
            |-> ##[1:2] capture_event[0];
    endproperty
    a_cap_rise: assert property (p_cap_rise) else $error("rise cap");
    property p_cap_fall;
        $fell(chan_in[0]) && en_r[0] && in0 && {en_r[3], en_r[1]} == 2'h1
            |-> ##[1:2] capture_event[0];
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("fall cap");
endmodule

// file: dv/tcep_pins.sv
// Purpose: Far-side pin model feeding the capture inputs
// Assumes: Commands arrive just after a rising edge
// Notes:   Levels persist; each flip bit toggles one lane pin
`timescale 1ns/100ps
module tcep_pins
(
    // Clock and reset
    input wire logic  mclk,
    input wire logic  reset_n,
    // Command
    input wire logic [4:0] flip,
    // Pins
    output logic [2:0] chan_in,
    output logic [1:0] comp_chan_in
);
    logic [4:0] lvl;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            lvl <= 5'h00;
        else
            lvl <= lvl ^ flip;
    end
    assign chan_in = {lvl[4], lvl[2], lvl[0]};
    assign comp_chan_in = {lvl[3], lvl[1]};
endmodule

// file: dv/tcep_top_bench.sv
// Purpose: Self-checking bench for the channel enable block
// Assumes: Every task starts just after a rising edge
// Notes:   Expected values come from the bench's own tables
`timescale 1ns/100ps
module tcep_top_bench;
    logic        mclk;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [2:0]  oc_ref;
    logic [2:0]  chan_in;
    logic [1:0]  comp_chan_in;
    logic [4:0]  outs;
    logic [4:0]  capture_event;
    logic [4:0]  flip;
    logic [4:0]  ex;
    logic [9:0]  en;
    logic [3:0]  rise_m;
    logic [3:0]  fall_m;
    int          error_cnt;
    int          checks_done;
    int          cnt [5];

    tcep_top i_tcep_top
    (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .oc_ref(oc_ref), .chan_in(chan_in),
        .comp_chan_in(comp_chan_in), .chan0_out(outs[0]),
        .comp_chan0_out(outs[1]), .chan1_out(outs[2]),
        .comp_chan1_out(outs[3]), .chan2_out(outs[4]),
        .capture_event(capture_event)
    );
    tcep_pins i_tcep_pins
    (
        .mclk(mclk), .reset_n(reset_n), .flip(flip),
        .chan_in(chan_in), .comp_chan_in(comp_chan_in)
    );

    always #4 mclk = ~mclk;

    function automatic logic [4:0] exp_out(logic [9:0] e, logic [15:0] m,
                                           logic [2:0] r);
        logic [4:0] o;
        o[0] = e[0] & (m[1:0] == 2'h0) & (r[0] ^ e[1]);
        o[1] = e[2] & (m[1:0] == 2'h0) & (~r[0] ^ (e[3] & (m[7:6] == 2'h3)));
        o[2] = e[4] & (m[3:2] == 2'h0) & (r[1] ^ e[5]);
        o[3] = e[6] & (m[3:2] == 2'h0) & (~r[1] ^ (e[7] & (m[9:8] == 2'h3)));
        o[4] = e[8] & (m[5:4] == 2'h0) & (r[2] ^ e[9]);
        return o;
    endfunction

    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask

    // Strobe drops at the taking edge; next task raises it 1 ns later
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask

    // Six cycles covers the pin flop plus the registered pulse
    task edge_cnt(input logic [4:0] m);
        flip <= m;
        cnt = '{default: 0};
        repeat (6)
        begin
            @(posedge mclk);
            flip <= 5'h00;
            #1;
            for (int k = 0; k < 5; k++)
                cnt[k] += (capture_event[k] !== 1'b0) ? 1 : 0;
        end
    endtask

    initial
    begin
        #100000;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        mclk = 1'b0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        oc_ref = 3'h0;
        flip = 5'h00;
        error_cnt = 0;
        checks_done = 0;
        rise_m = 4'h9;
        fall_m = 4'ha;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        chk("outputs", 32'h0, {27'h0, outs});
        rd(tcep_pkg::OFS_CHAN_ENABLE, 32'h0, "enable reset");
        $display("test reset done");
        // Output and input modes against every reference; comp select follows with one reference
        for (int i = 0; i < 3; i++)
            for (int j = 0; j < 6; j++)
            begin
                en = (j == 5) ? 10'h3ff : 10'h003 << (2 * j);
                wr(tcep_pkg::OFS_CHAN_MODE, 32'h0015 >> (3 - i) * 2);
                wr(tcep_pkg::OFS_CHAN_ENABLE, {22'h0, en});
                for (int r = 0; r < 8; r++)
                begin
                    oc_ref <= r[2:0];
                    repeat (2) @(posedge mclk);
                    #1;
                    ex = exp_out(en, 16'h0015 >> (3 - i) * 2, r[2:0]);
                    chk("outs", 32'(ex), 32'(outs));
                end
            end
        wr(tcep_pkg::OFS_CHAN_MODE, 32'h03c0);
        wr(tcep_pkg::OFS_CHAN_ENABLE, 32'h0000_000c);
        oc_ref <= 3'h1;
        repeat (2) @(posedge mclk);
        #1;
        chk("comp sel", 32'h2, {27'h0, outs});
        $display("test outputs done");
        wr(tcep_pkg::OFS_CHAN_ENABLE, 32'hffff_ffff);
        rd(tcep_pkg::OFS_CHAN_ENABLE, 32'h3ff, "enable reg");
        for (int p = 2; p < 4; p++)
        begin
            wr(tcep_pkg::OFS_PROTECT, 32'(p));
            wr(tcep_pkg::OFS_CHAN_ENABLE, 32'h0);
            rd(tcep_pkg::OFS_CHAN_ENABLE, 32'h2aa, "locked clr");
            wr(tcep_pkg::OFS_CHAN_ENABLE, 32'h155);
            rd(tcep_pkg::OFS_CHAN_ENABLE, 32'h3ff, "locked set");
        end
        wr(tcep_pkg::OFS_PROTECT, 32'h1);
        rd(tcep_pkg::OFS_PROTECT, 32'h1, "protect");
        wr(tcep_pkg::OFS_CHAN_ENABLE, 32'h0);
        rd(tcep_pkg::OFS_CHAN_ENABLE, 32'h0, "open clr");
        rd(8'h10, 32'h0, "unmapped");
        $display("test protect done");
        wr(tcep_pkg::OFS_CHAN_MODE, 32'h0015);
        for (int s = 0; s < 4; s++)
        begin
            en = {2'h0, s[1], 1'b1, s[0], 1'b1, s[1], 1'b1, s[0], 1'b1};
            wr(tcep_pkg::OFS_CHAN_ENABLE, {22'h0, en});
            edge_cnt(5'h0f);
            chk("rise ch0", {31'h0, rise_m[s]}, 32'(cnt[0]));
            chk("rise cmp0", {31'h0, rise_m[s]}, 32'(cnt[1]));
            chk("rise ch1", {31'h0, rise_m[s]}, 32'(cnt[2]));
            chk("rise cmp1", {31'h0, rise_m[s]}, 32'(cnt[3]));
            edge_cnt(5'h0f);
            chk("fall ch0", {31'h0, fall_m[s]}, 32'(cnt[0]));
            chk("fall cmp0", {31'h0, fall_m[s]}, 32'(cnt[1]));
            chk("fall ch1", {31'h0, fall_m[s]}, 32'(cnt[2]));
            chk("fall cmp1", {31'h0, fall_m[s]}, 32'(cnt[3]));
        end
        $display("test edges done");
        // Divide by two on channel 2, restarted by the enable
        wr(tcep_pkg::OFS_CHAN_MODE, 32'h4015);
        wr(tcep_pkg::OFS_CHAN_ENABLE, 32'h100);
        edge_cnt(5'h10);
        chk("psc first", 32'h0, 32'(cnt[4]));
        edge_cnt(5'h10);
        wr(tcep_pkg::OFS_CHAN_ENABLE, 32'h0);
        wr(tcep_pkg::OFS_CHAN_ENABLE, 32'h100);
        edge_cnt(5'h10);
        chk("psc cleared", 32'h0, 32'(cnt[4]));
        edge_cnt(5'h10);
        edge_cnt(5'h10);
        chk("psc second", 32'h1, 32'(cnt[4]));
        $display("test prescaler done");
        // Every lane has captured by now; channel 2 pin was left high
        rd(tcep_pkg::OFS_CAPT_FLAGS, 32'h1f, "flags set");
        wr(tcep_pkg::OFS_CAPT_FLAGS, 32'h1f);
        rd(tcep_pkg::OFS_CAPT_FLAGS, 32'h0, "flags clear");
        rd(tcep_pkg::OFS_PIN_STATE, 32'h200, "pin state");
        $display("test registers done");
        end_sim();
    end
endmodule

bind tcep_top tcep_props i_tcep_props
(
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .oc_ref(oc_ref), .chan_in(chan_in),
    .chan0_out(chan0_out), .comp_chan0_out(comp_chan0_out),
    .chan1_out(chan1_out), .comp_chan1_out(comp_chan1_out),
    .chan2_out(chan2_out), .capture_event(capture_event)
);
